// [design/spso_core.sv]
// Suspend pin override, revision register and second bus status indicator
`timescale 1ns/10ps
`default_nettype none

module spso_core
  import spso_pkg::*;
#(
  parameter logic [15:0] REVISION = 16'h00a5 // Arbitrary value
)
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic [9:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [15:0] RDATA,
  input  wire logic        SUSPEND,
  input  wire logic        BUS_RESET,
  input  wire logic        CONFIGURED,
  input  wire logic        HIGH_POWER,
  input  wire logic [15:0] NORM_O,
  input  wire logic [15:0] NORM_OE,
  output var  logic [15:0] PIN_O,
  output var  logic [15:0] PIN_OE,
  input  wire logic        STAT2_I,
  output var  logic        STAT2_O,
  output var  logic        STAT2_OE
);

  spso_bus_t   bus;
  spso_state_t st_q;
  spso_state_t st_d;
  logic [15:0] susp_o;
  logic [15:0] susp_oe;
  logic        override;
  logic        unconf_hp;
  logic        ind_level;

  // Bundle the register port
  assign bus.wr    = WR;
  assign bus.rd    = RD;
  assign bus.addr  = ADDR;
  assign bus.wdata = WDATA;

  assign override  = st_q.drive_q[SPSO_BIT_OVERRIDE];
  assign unconf_hp = HIGH_POWER & ~CONFIGURED;

  // Per-pin suspend value; open-drain only pulls low, releases for a high
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_pin
      assign susp_o[gi]  = SPSO_PIN_MASK[gi] & st_q.level_q[gi] & ~st_q.drive_q[gi];
      assign susp_oe[gi] = SPSO_PIN_MASK[gi] & (~st_q.drive_q[gi] | ~st_q.level_q[gi]);
    end
  endgenerate

  // Indicator decode from the select field
  always_comb
  begin
    case (st_q.second_indicator_select_q)
      SPSO_SEL_SUSP_RST_HI:  ind_level = SUSPEND | BUS_RESET;
      SPSO_SEL_SUSP_HI:      ind_level = SUSPEND;
      SPSO_SEL_POWER_HI:     ind_level = SUSPEND | unconf_hp;
      SPSO_SEL_RST_HI:       ind_level = BUS_RESET;
      SPSO_SEL_SUSP_RST_HI2: ind_level = SUSPEND | BUS_RESET;
      SPSO_SEL_SUSP_LO:      ind_level = ~SUSPEND;
      SPSO_SEL_POWER_LO:     ind_level = ~(SUSPEND | unconf_hp);
      SPSO_SEL_RST_LO:       ind_level = ~BUS_RESET;
      default:               ind_level = 1'b0;
    endcase
  end

  // Next state: registers, read data, pins, indicator
  always_comb
  begin
    st_d = st_q;
    // Pin level passes two flops before anyone looks at it
    st_d.lvl2_meta_q = STAT2_I;
    st_d.lvl2_sync_q = st_q.lvl2_meta_q;

    // Reserved bits are never stored, so they read back as zero
    if (bus.wr)
    begin
      case (bus.addr)
        SPSO_OFS_LEVEL: st_d.level_q = bus.wdata & SPSO_LEVEL_WMASK;
        SPSO_OFS_DRIVE: st_d.drive_q = bus.wdata & SPSO_DRIVE_WMASK;
        SPSO_OFS_STATUS: st_d.second_indicator_select_q = bus.wdata[SPSO_SECOND_INDICATOR_SELECT_LSB +: 3];
        default: st_d.second_indicator_select_q = st_q.second_indicator_select_q; // Revision and unmapped: ignored
      endcase
    end

    // Read data stands for one cycle only
    st_d.rdata_q = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        SPSO_OFS_LEVEL:    st_d.rdata_q = st_q.level_q;
        SPSO_OFS_DRIVE:    st_d.rdata_q = st_q.drive_q;
        SPSO_OFS_REVISION: st_d.rdata_q = REVISION;
        SPSO_OFS_STATUS:
        begin
          st_d.rdata_q[SPSO_BIT_LEVEL2]      = st_q.lvl2_sync_q;
          st_d.rdata_q[SPSO_SECOND_INDICATOR_SELECT_LSB +: 3]   = st_q.second_indicator_select_q;
        end
        default:           st_d.rdata_q = 16'h0000;
      endcase
    end

    // Pin selection; holding the last value keeps a frozen core from glitching pins
    if (SUSPEND && override)
    begin
      st_d.pin_o_q  = susp_o;
      st_d.pin_oe_q = susp_oe;
    end
    else if (SUSPEND)
    begin
      st_d.pin_o_q  = st_q.pin_o_q;
      st_d.pin_oe_q = st_q.pin_oe_q;
    end
    else
    begin
      st_d.pin_o_q  = NORM_O & SPSO_PIN_MASK;
      st_d.pin_oe_q = NORM_OE & SPSO_PIN_MASK;
    end

    st_d.stat2_o_q  = ind_level;
    st_d.stat2_oe_q = 1'b1;
  end

  // State register
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q             <= '0;
      st_q.level_q     <= SPSO_LEVEL_RST;
      st_q.drive_q     <= SPSO_DRIVE_RST;
      st_q.second_indicator_select_q      <= SPSO_SECOND_INDICATOR_SELECT_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign RDATA    = st_q.rdata_q;
  assign PIN_O    = st_q.pin_o_q;
  assign PIN_OE   = st_q.pin_oe_q;
  assign STAT2_O  = st_q.stat2_o_q;
  assign STAT2_OE = st_q.stat2_oe_q;

  // Checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_susp_ovr;
    SUSPEND && override;
  endsequence

  sequence s_read_status;
    RD && (ADDR == SPSO_OFS_STATUS);
  endsequence

  property p_retain;
    SUSPEND && !override |=> (PIN_O == $past(PIN_O)) && (PIN_OE == $past(PIN_OE));
  endproperty
  a_retain: assert property (p_retain) else $error("pins moved in suspend without override");

  property p_level;
    s_susp_ovr |=> ((PIN_O | ~PIN_OE) & SPSO_PIN_MASK) == ($past(st_q.level_q) & SPSO_PIN_MASK);
  endproperty
  a_level: assert property (p_level) else $error("suspend level not applied");

  property p_push_pull;
    s_susp_ovr |=> ((PIN_OE | $past(st_q.drive_q)) & SPSO_PIN_MASK) == SPSO_PIN_MASK;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

  property p_open_drain;
    s_susp_ovr |=> (PIN_O & $past(st_q.drive_q) & SPSO_PIN_MASK) == 16'h0000;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

  property p_reserved;
    WR && (ADDR == SPSO_OFS_DRIVE) |=> (st_q.drive_q & ~SPSO_DRIVE_WMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved drive bit stored");

  property p_level2;
    s_read_status ##1 1'b1 |-> RDATA[SPSO_BIT_LEVEL2] == $past(st_q.lvl2_sync_q);
  endproperty
  a_level2: assert property (p_level2) else $error("indicator level read wrong");

  property p_sel_both_hi;
    (st_q.second_indicator_select_q == SPSO_SEL_SUSP_RST_HI || st_q.second_indicator_select_q == SPSO_SEL_SUSP_RST_HI2)
      && (SUSPEND || BUS_RESET) |=> STAT2_O;
  endproperty
  a_sel_both_hi: assert property (p_sel_both_hi) else $error("indicator not high on suspend or reset");

  property p_sel_susp;
    st_q.second_indicator_select_q == SPSO_SEL_SUSP_HI |=> STAT2_O == $past(SUSPEND);
  endproperty
  a_sel_susp: assert property (p_sel_susp) else $error("indicator does not follow suspend");

  property p_sel_power;
    st_q.second_indicator_select_q == SPSO_SEL_POWER_HI |=> STAT2_O == $past(SUSPEND || (HIGH_POWER && !CONFIGURED));
  endproperty
  a_sel_power: assert property (p_sel_power) else $error("power indicator wrong");

  property p_sel_rst;
    st_q.second_indicator_select_q == SPSO_SEL_RST_HI |=> STAT2_O == $past(BUS_RESET);
  endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("reset indicator wrong");

  property p_sel_susp_lo;
    st_q.second_indicator_select_q == SPSO_SEL_SUSP_LO |=> STAT2_O == !$past(SUSPEND);
  endproperty
  a_sel_susp_lo: assert property (p_sel_susp_lo) else $error("low suspend indicator wrong");

  property p_sel_power_lo;
    st_q.second_indicator_select_q == SPSO_SEL_POWER_LO |=> STAT2_O == !$past(SUSPEND || (HIGH_POWER && !CONFIGURED));
  endproperty
  a_sel_power_lo: assert property (p_sel_power_lo) else $error("low power indicator wrong");

  property p_sel_rst_lo;
    st_q.second_indicator_select_q == SPSO_SEL_RST_LO |=> STAT2_O == !$past(BUS_RESET);
  endproperty
  a_sel_rst_lo: assert property (p_sel_rst_lo) else $error("low reset indicator wrong");

  property p_resume;
    !SUSPEND |=> (PIN_O == ($past(NORM_O) & SPSO_PIN_MASK)) && (PIN_OE == ($past(NORM_OE) & SPSO_PIN_MASK));
  endproperty
  a_resume: assert property (p_resume) else $error("pins not back to normal after suspend");

  property p_revision;
    RD && (ADDR == SPSO_OFS_REVISION) |=> RDATA == REVISION;
  endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");

  // Register bus steps, one sequence per kind of access except the revision read
  sequence s_write_level;
    WR && (ADDR == SPSO_OFS_LEVEL);
  endsequence

  sequence s_write_drive;
    WR && (ADDR == SPSO_OFS_DRIVE);
  endsequence

  sequence s_write_status;
    WR && (ADDR == SPSO_OFS_STATUS);
  endsequence

  sequence s_write_revision;
    WR && (ADDR == SPSO_OFS_REVISION);
  endsequence

  sequence s_read_level;
    RD && (ADDR == SPSO_OFS_LEVEL);
  endsequence

  sequence s_read_drive;
    RD && (ADDR == SPSO_OFS_DRIVE);
  endsequence

  // Leaving suspend takes one sampled cycle of each level
  sequence s_leave_susp;
    SUSPEND ##1 !SUSPEND;
  endsequence

  // Stored values are the written word less its reserved bits
  property p_level_store;
    s_write_level |=> st_q.level_q == ($past(WDATA) & SPSO_LEVEL_WMASK);
  endproperty
  a_level_store: assert property (p_level_store) else $error("level register not stored");

  property p_drive_store;
    s_write_drive |=> st_q.drive_q == ($past(WDATA) & SPSO_DRIVE_WMASK);
  endproperty
  a_drive_store: assert property (p_drive_store) else $error("drive register not stored");

  property p_sel_store;
    s_write_status |=> st_q.second_indicator_select_q == $past(WDATA[SPSO_SECOND_INDICATOR_SELECT_LSB +: 3]);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("indicator select not stored");

  // A write to the fixed word must not leak into a writable one
  property p_rev_write;
    s_write_revision |=> $stable(st_q.level_q) && $stable(st_q.drive_q) && $stable(st_q.second_indicator_select_q);
  endproperty
  a_rev_write: assert property (p_rev_write) else $error("revision write changed a register");

  // Read-back of the writable words
  property p_read_level;
    s_read_level |=> RDATA == $past(st_q.level_q);
  endproperty
  a_read_level: assert property (p_read_level) else $error("level read wrong");

  property p_read_drive;
    s_read_drive |=> RDATA == $past(st_q.drive_q);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("drive read wrong");

  property p_status_fmt;
    s_read_status |=> (RDATA & ~16'h3c00) == 16'h0000;
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status reserved bits not zero");

  property p_sel_read;
    s_read_status |=> RDATA[SPSO_SECOND_INDICATOR_SELECT_LSB +: 3] == $past(st_q.second_indicator_select_q);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("indicator select read wrong");

  // Two flops between pad and readable level; skipping one invites metastability
  property p_meta;
    RESETN |=> st_q.lvl2_meta_q == $past(STAT2_I);
  endproperty
  a_meta: assert property (p_meta) else $error("first sync stage wrong");

  property p_sync;
    RESETN |=> st_q.lvl2_sync_q == $past(st_q.lvl2_meta_q);
  endproperty
  a_sync: assert property (p_sync) else $error("second sync stage wrong");

  // Indicator is actively driven except in reset; open drain is not offered
  property p_stat2_oe;
    1'b1 |=> STAT2_OE;
  endproperty
  a_stat2_oe: assert property (p_stat2_oe) else $error("indicator not driven");

  property p_sel_both_lo;
    (st_q.second_indicator_select_q == SPSO_SEL_SUSP_RST_HI || st_q.second_indicator_select_q == SPSO_SEL_SUSP_RST_HI2)
      && !SUSPEND && !BUS_RESET |=> !STAT2_O;
  endproperty
  a_sel_both_lo: assert property (p_sel_both_lo) else $error("indicator high while idle");

  // Pins outside the covered set stay released and low
  property p_uncovered;
    ((PIN_O | PIN_OE) & ~SPSO_PIN_MASK) == 16'h0000;
  endproperty
  a_uncovered: assert property (p_uncovered) else $error("uncovered pin driven");

  property p_leave;
    s_leave_susp |=> PIN_OE == ($past(NORM_OE) & SPSO_PIN_MASK);
  endproperty
  a_leave: assert property (p_leave) else $error("drivers not restored on resume");

endmodule // spso_core

`default_nettype wire

// [inc/spso_pkg.sv]
// Package: constants and types of the suspend pin override and bus status indicator block
// Operation
// - Override off: outputs keep level and driver.
// - Override on: suspended pins take programmed values.
// - Drive bit 0 gives push-pull output.
// - Drive bit 1 gives open-drain output.
// - Indicator level bit is live, read-only.
// - Select 000: high on suspend or reset.
// - Select 001: high while suspended.
// - Select 010: high suspended, or unconfigured high-power.
// - Select 011: high during bus reset.
// - Select 100: high on suspend or reset.
// - Select 101: low while suspended.
// - Select 110: low suspended, or unconfigured high-power.
// - Select 111: low during bus reset.
// - Level bit 1 high, 0 low.
package spso_pkg;

  localparam int          SPSO_AW            = 10;
  localparam int          SPSO_DW            = 16;

  // Register offsets
  localparam logic [9:0]  SPSO_OFS_LEVEL     = 10'h06a;
  localparam logic [9:0]  SPSO_OFS_DRIVE     = 10'h06b;
  localparam logic [9:0]  SPSO_OFS_REVISION  = 10'h260;
  localparam logic [9:0]  SPSO_OFS_STATUS    = 10'h262;

  // Field positions
  localparam int          SPSO_BIT_OVERRIDE  = 15;
  localparam int          SPSO_BIT_LEVEL2    = 13;
  localparam int          SPSO_SECOND_INDICATOR_SELECT_LSB      = 10;

  // Covered pins and writable bits
  localparam logic [15:0] SPSO_PIN_MASK      = 16'h3ccf;
  localparam logic [15:0] SPSO_DRIVE_WMASK   = 16'hbccf;
  localparam logic [15:0] SPSO_LEVEL_WMASK   = 16'h3ccf;

  // Values after reset
  localparam logic [15:0] SPSO_LEVEL_RST     = 16'h0000;
  localparam logic [15:0] SPSO_DRIVE_RST     = 16'h0000;
  localparam logic [2:0]  SPSO_SECOND_INDICATOR_SELECT_RST      = 3'h0;

  // Indicator select codes
  localparam logic [2:0]  SPSO_SEL_SUSP_RST_HI = 3'h0;
  localparam logic [2:0]  SPSO_SEL_SUSP_HI     = 3'h1;
  localparam logic [2:0]  SPSO_SEL_POWER_HI    = 3'h2;
  localparam logic [2:0]  SPSO_SEL_RST_HI      = 3'h3;
  localparam logic [2:0]  SPSO_SEL_SUSP_RST_HI2 = 3'h4;
  localparam logic [2:0]  SPSO_SEL_SUSP_LO     = 3'h5;
  localparam logic [2:0]  SPSO_SEL_POWER_LO    = 3'h6;
  localparam logic [2:0]  SPSO_SEL_RST_LO      = 3'h7;

  // Register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [9:0]        addr;
    logic [15:0]       wdata;
  } spso_bus_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0]       level_q;
    logic [15:0]       drive_q;
    logic [2:0]        second_indicator_select_q;
    logic [15:0]       rdata_q;
    logic              lvl2_meta_q;
    logic              lvl2_sync_q;
    logic [15:0]       pin_o_q;
    logic [15:0]       pin_oe_q;
    logic              stat2_o_q;
    logic              stat2_oe_q;
  } spso_state_t;

endpackage

// [verification/spso_board.sv]
// Board pull-ups on the covered pins and the indicator pad
`timescale 1ns/10ps
`default_nettype none
module spso_board
(
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe,
  input  wire logic        stat2_o,
  input  wire logic        stat2_oe,
  output var  logic [15:0] pad,
  output var  logic        stat2_pad
);
  // Released pins float up, so open drain reads high
  always_comb pad = (pin_o & pin_oe) | ~pin_oe;
  // Indicator pad level fed back to the sampler
  always_comb stat2_pad = stat2_oe ? stat2_o : 1'b1;
endmodule // spso_board
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the suspend pin override block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spso_pkg::*;
  localparam logic [15:0] REV = 16'h3e97; // Arbitrary value
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  cond = 4'h0;
  logic [9:0]  addr = 10'h000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] norm_o = 16'h0000;
  logic [15:0] norm_oe = 16'h0000;
  logic [15:0] rdata, pin_o, pin_oe, pad, d;
  logic        stat2_i, stat2_o, stat2_oe;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  spso_core #(.REVISION(REV)) spso_core_inst (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SUSPEND(cond[0]), .BUS_RESET(cond[1]), .CONFIGURED(cond[2]),
    .HIGH_POWER(cond[3]), .NORM_O(norm_o), .NORM_OE(norm_oe), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .STAT2_I(stat2_i), .STAT2_O(stat2_o), .STAT2_OE(stat2_oe));
  spso_board spso_board_inst (.pin_o(pin_o), .pin_oe(pin_oe), .stat2_o(stat2_o), .stat2_oe(stat2_oe),
    .pad(pad), .stat2_pad(stat2_i));

  // Free-running core clock
  always #12.5 mclk = ~mclk;

  task automatic end_sim();
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, about ten times the roughly 500 cycles needed
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %0t %s", $time, m);
      miscompares++;
    end
  endtask

  task automatic bus_wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  function automatic logic ind(input logic [2:0] s, input logic [3:0] c);
    logic u;
    u = c[3] & ~c[2];
    case (s)
      3'h0, 3'h4: ind = c[0] | c[1];
      3'h1: ind = c[0];
      3'h2: ind = c[0] | u;
      3'h3: ind = c[1];
      3'h5: ind = ~c[0];
      3'h6: ind = ~(c[0] | u);
      default: ind = ~c[1];
    endcase
  endfunction

  task automatic t_regs();
    bus_wr(SPSO_OFS_REVISION, 16'hffff);
    bus_wr(10'h3ff, 16'h1234);
    bus_rd(SPSO_OFS_REVISION, d);
    chk(d, REV, "revision");
    bus_rd(10'h3ff, d);
    chk(d, 16'h0000, "unmapped");
    bus_rd(SPSO_OFS_DRIVE, d);
    chk(d, SPSO_DRIVE_RST, "drive reset");
    bus_rd(SPSO_OFS_LEVEL, d);
    chk(d, SPSO_LEVEL_RST, "level reset");
    bus_rd(SPSO_OFS_STATUS, d);
    chk(d, {2'h0, ind(SPSO_SECOND_INDICATOR_SELECT_RST, 4'h0), SPSO_SECOND_INDICATOR_SELECT_RST, 10'h000}, "status reset");
    chk({15'h0, stat2_oe}, 16'h0001, "indicator enable");
  endtask

  // Suspend without override freezes the pins
  task automatic t_hold();
    @(posedge mclk);
    norm_o  <= 16'h1248;
    norm_oe <= 16'hffff;
    settle();
    chk(pin_o, 16'h1248 & SPSO_PIN_MASK, "normal level");
    @(posedge mclk);
    cond <= 4'h1;
    @(posedge mclk);
    norm_o  <= 16'hffff;
    norm_oe <= 16'h0000;
    settle();
    chk(pin_o, 16'h1248 & SPSO_PIN_MASK, "held level");
    chk(pin_oe, SPSO_PIN_MASK, "held driver");
    @(posedge mclk);
    cond <= 4'h0;
    settle();
    chk(pin_oe, 16'h0000, "resume");
    chk(pin_o, SPSO_PIN_MASK, "resume level");
  endtask

  // Mixed push-pull and open-drain pins, both levels
  task automatic t_override();
    bus_wr(SPSO_OFS_LEVEL, 16'h28c5);
    bus_wr(SPSO_OFS_DRIVE, 16'hb088);
    bus_rd(SPSO_OFS_DRIVE, d);
    chk(d, 16'hb088, "drive readback");
    @(posedge mclk);
    cond <= 4'h1;
    settle();
    chk(pin_o, 16'h28c5 & ~16'hb088 & SPSO_PIN_MASK, "suspend level");
    chk(pin_oe, (~16'hb088 | ~16'h28c5) & SPSO_PIN_MASK, "suspend driver");
    chk(pad & SPSO_PIN_MASK, 16'h28c5 & SPSO_PIN_MASK, "pad level");
    @(posedge mclk);
    cond <= 4'h0;
    settle();
    chk(pin_oe, 16'h0000, "restored");
  endtask

  // Every select code against every bus condition
  task automatic t_sel();
    for (int s = 0; s < 8; s++)
    begin
      bus_wr(SPSO_OFS_STATUS, {3'h1, 3'(s), 10'h000});
      for (int c = 0; c < 16; c++)
      begin
        @(posedge mclk);
        cond <= 4'(c);
        settle();
        chk({15'h0, stat2_o}, {15'h0, ind(3'(s), 4'(c))}, "indicator");
      end
      bus_rd(SPSO_OFS_STATUS, d);
      chk(d, {2'h0, ind(3'(s), 4'hf), 3'(s), 10'h000}, "status");
    end
  endtask

  // Reset in mid-run: outputs released at once, registers back to defaults
  task automatic t_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk({15'h0, stat2_oe}, 16'h0000, "indicator enable in reset");
    chk(pin_oe, 16'h0000, "pins in reset");
    @(posedge mclk);
    resetn <= 1'b1;
    bus_rd(SPSO_OFS_DRIVE, d);
    chk(d, SPSO_DRIVE_RST, "drive after reset");
    bus_rd(SPSO_OFS_STATUS, d);
    chk(d, {2'h0, ind(SPSO_SECOND_INDICATOR_SELECT_RST, 4'hf), SPSO_SECOND_INDICATOR_SELECT_RST, 10'h000}, "status after reset");
    settle();
    chk({15'h0, stat2_o}, {15'h0, ind(SPSO_SECOND_INDICATOR_SELECT_RST, 4'hf)}, "indicator after reset");
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_hold();
    t_override();
    t_sel();
    t_reset();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
